//--- hw/ddp_regs.vh
/*
  Constants of the DDR2 pin-behaviour block: command codes, mode bits,
  widths and the data FIFO shape.
  Assumes inclusion by bare name from the design files under hw/.
*/
// Contract
// - Decode commands only when chip select low
// - Chip select gates decode; it is not part of command code
// - Row, column, write strobes define command
// - Fully masked write beats are not stored
// - Mask sampled on both strobe edges
// - Lower mask bits 7:0, upper 15:8
// - Termination on when control registered high
// - Termination only on active-width data pins
// - Mode-disabled termination ignores control input
// - Data width follows x16, x8, x4
// - Device drives strobe with read data
// - Read strobe edges aligned with data
// - Strobe complement used only in differential mode
// - Each byte lane has own strobe pair; writes capture both lanes on the lower strobe
// - Redundant strobe only x8, set by mode
// - Redundant strobe driven only with reads
// - Disabled redundant strobe acts as mask
// - Redundant complement needs both modes enabled
// - Commands sampled on rising link clock
`ifndef DDP_REGS_VH
`define DDP_REGS_VH
`define DDP_WIDTH_X16 2'h2
`define DDP_WIDTH_X8 2'h1
`define DDP_WIDTH_X4 2'h0
`define DDP_CMD_LMR 3'h0
`define DDP_CMD_WRITE 3'h4
`define DDP_CMD_READ 3'h5
`define DDP_CMD_NOP 3'h7
`define DDP_MODE_BITS 4
`define DDP_MODE_ODT_OFF 0
`define DDP_MODE_DIFF_OFF 1
`define DDP_MODE_REDUNDANT_READ_STROBE_COMPLEMENT_ON 2
`define DDP_MODE_RESET 4'h0
`define DDP_BA_EXT 3'h1
`define DDP_DATA_W 16
`define DDP_BEAT_W 18
`define DDP_FIFO_DEPTH 4
`define DDP_FIFO_AW 2
`define DDP_LANE_W 8
`define DDP_MASK_W 2
`define DDP_SYNC_IDLE 10'h1E0
`define DDP_BURST_BEATS 3'h4
`endif

//--- hw/ddp_fifo.v
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module ddp_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

//--- hw/ddp_pins.v
/*
  DDR2 device pin behaviour: command qualification by chip select,
  termination control, write capture with byte masks into a FIFO,
  read data with edge-aligned strobes, redundant strobe option.
  Assumes link clock and strobes are slow pins sampled by clock_i;
  organisation chosen by org_i, a static strap.
*/
`timescale 1ns/100ps
`include "ddp_regs.vh"
module ddp_pins (
  input wire clock_i,
  input wire rst_n_i,
  input wire [1:0] org_i,
  input wire link_clk_i,
  input wire chip_select_n_i,
  input wire row_strobe_n_i,
  input wire col_strobe_n_i,
  input wire write_enable_n_i,
  input wire [2:0] bank_i,
  input wire [`DDP_MODE_BITS-1:0] mode_op_i,
  input wire termination_control_i,
  input wire [`DDP_DATA_W-1:0] dq_i,
  output reg [`DDP_DATA_W-1:0] dq_o,
  output reg [`DDP_DATA_W-1:0] dq_oe_o,
  input wire lower_byte_mask_i,
  input wire upper_byte_mask_i,
  input wire lower_byte_strobe_i,
  output reg lower_byte_strobe_o,
  output reg lower_byte_strobe_oe_o,
  output reg lower_byte_strobe_n_o,
  output reg lower_byte_strobe_n_oe_o,
  output reg upper_byte_strobe_o,
  output reg upper_byte_strobe_oe_o,
  output reg upper_byte_strobe_n_o,
  output reg upper_byte_strobe_n_oe_o,
  output reg redundant_read_strobe_o,
  output reg redundant_read_strobe_oe_o,
  output reg redundant_read_strobe_complement_o,
  output reg redundant_read_strobe_complement_oe_o,
  output reg [`DDP_DATA_W-1:0] termination_on_o,
  output reg [2:0] last_cmd_o,
  output reg [`DDP_MODE_BITS-1:0] ext_mode_o,
  output reg wr_valid_o,
  input wire wr_ready_i,
  output reg [`DDP_DATA_W-1:0] wr_data_o,
  output reg [`DDP_MASK_W-1:0] wr_keep_o,
  input wire [`DDP_DATA_W-1:0] rd_data_i,
  input wire rd_valid_i,
  output reg rd_ready_o,
  output reg write_stall_o
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [9:0] sync1;
  reg [9:0] sync2;
  reg [2:0] bank_s1;
  reg [2:0] bank_s2;
  reg [`DDP_MODE_BITS-1:0] op_s1;
  reg [`DDP_MODE_BITS-1:0] op_s2;
  reg [`DDP_DATA_W-1:0] dq_s1;
  reg [`DDP_DATA_W-1:0] dq_s2;
  reg clk_d;
  reg dqs_d;
  wire [9:0] raw;
  assign raw = {link_clk_i, chip_select_n_i, row_strobe_n_i, col_strobe_n_i,
                write_enable_n_i, termination_control_i, lower_byte_mask_i,
                upper_byte_mask_i, lower_byte_strobe_i, 1'b0};
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync1 <= `DDP_SYNC_IDLE;
      sync2 <= `DDP_SYNC_IDLE;
      bank_s1 <= 3'h0;
      bank_s2 <= 3'h0;
      op_s1 <= `DDP_MODE_RESET;
      op_s2 <= `DDP_MODE_RESET;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      clk_d <= 1'b0;
      dqs_d <= 1'b0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      bank_s1 <= bank_i;
      bank_s2 <= bank_s1;
      op_s1 <= mode_op_i;
      op_s2 <= op_s1;
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      clk_d <= sync2[9];
      dqs_d <= sync2[1];
    end
  end
  wire lclk = sync2[9];
  wire cs_n = sync2[8];
  wire ras_n = sync2[7];
  wire cas_n = sync2[6];
  wire we_n = sync2[5];
  wire odt_in = sync2[4];
  wire lower_byte_mask = sync2[3];
  wire upper_byte_mask = sync2[2];
  wire dqs = sync2[1];
  wire clk_rise = lclk & ~clk_d;
  wire clk_fall = ~lclk & clk_d;
  wire dqs_edge = dqs ^ dqs_d;
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  wire cmd_ok = clk_rise & ~cs_n;
  reg in_write;
  reg in_read;
  reg [2:0] beats;
  wire is_x8 = (org_i == `DDP_WIDTH_X8);
  wire redundant_read_strobe_complement_on = ext_mode_o[`DDP_MODE_REDUNDANT_READ_STROBE_COMPLEMENT_ON] & is_x8;
  wire diff_on = ~ext_mode_o[`DDP_MODE_DIFF_OFF];
  reg [`DDP_DATA_W-1:0] width_mask;
  always @* begin
    case (org_i)
      `DDP_WIDTH_X16: width_mask = 16'hFFFF;
      `DDP_WIDTH_X8: width_mask = 16'h00FF;
      default: width_mask = 16'h000F;
    endcase
  end
  // ----------------------------------------------------------------
  // Mode, termination and transfer state
  // ----------------------------------------------------------------
  wire odt_q = odt_in & ~ext_mode_o[`DDP_MODE_ODT_OFF];
  wire lane_mask = (org_i == `DDP_WIDTH_X16) ? lower_byte_mask : (redundant_read_strobe_complement_on ? 1'b0 : lower_byte_mask);
  wire [`DDP_MASK_W-1:0] keep = {~upper_byte_mask, ~lane_mask};
  wire beat_store = in_write & dqs_edge & (keep != 2'h0);
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      ext_mode_o <= `DDP_MODE_RESET;
      last_cmd_o <= `DDP_CMD_NOP;
      termination_on_o <= 16'h0000;
      in_write <= 1'b0;
      in_read <= 1'b0;
      beats <= 3'h0;
      wr_valid_o <= 1'b0;
      wr_data_o <= 16'h0000;
      wr_keep_o <= 2'h0;
      write_stall_o <= 1'b0;
    end else begin
      if (clk_rise || ext_mode_o[`DDP_MODE_ODT_OFF])
        termination_on_o <= odt_q ? width_mask : 16'h0000;
      if (in_write && dqs_edge) begin
        beats <= beats - 3'h1;
        if (beats == 3'h1)
          in_write <= 1'b0;
      end
      if (in_read && (clk_rise || clk_fall) && rd_valid_i) begin
        beats <= beats - 3'h1;
        if (beats == 3'h1)
          in_read <= 1'b0;
      end
      // A new command wins over the end of a burst
      if (cmd_ok) begin
        last_cmd_o <= cmd;
        if (cmd == `DDP_CMD_LMR && bank_s2 == `DDP_BA_EXT)
          ext_mode_o <= op_s2;
        if (cmd == `DDP_CMD_WRITE) begin
          in_write <= 1'b1;
          beats <= `DDP_BURST_BEATS;
        end
        if (cmd == `DDP_CMD_READ) begin
          in_read <= 1'b1;
          beats <= `DDP_BURST_BEATS;
        end
      end
      wr_valid_o <= beat_store;
      wr_data_o <= dq_s2 & width_mask;
      wr_keep_o <= keep;
      write_stall_o <= ~wr_ready_i;
    end
  end
  // ----------------------------------------------------------------
  // Read drive: data and strobe change on the same link edge
  // ----------------------------------------------------------------
  wire rd_edge = in_read & (clk_rise | clk_fall) & rd_valid_i;
  wire rd_on = in_read | rd_edge;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      dq_o <= 16'h0000;
      dq_oe_o <= 16'h0000;
      rd_ready_o <= 1'b0;
      lower_byte_strobe_o <= 1'b0;
      lower_byte_strobe_oe_o <= 1'b0;
      lower_byte_strobe_n_o <= 1'b1;
      lower_byte_strobe_n_oe_o <= 1'b0;
      upper_byte_strobe_o <= 1'b0;
      upper_byte_strobe_oe_o <= 1'b0;
      upper_byte_strobe_n_o <= 1'b1;
      upper_byte_strobe_n_oe_o <= 1'b0;
      redundant_read_strobe_o <= 1'b0;
      redundant_read_strobe_oe_o <= 1'b0;
      redundant_read_strobe_complement_o <= 1'b1;
      redundant_read_strobe_complement_oe_o <= 1'b0;
    end else begin
      rd_ready_o <= rd_edge;
      if (rd_edge) begin
        dq_o <= rd_data_i & width_mask;
        lower_byte_strobe_o <= clk_rise;
        lower_byte_strobe_n_o <= ~clk_rise;
        upper_byte_strobe_o <= clk_rise;
        upper_byte_strobe_n_o <= ~clk_rise;
        redundant_read_strobe_o <= clk_rise;
        redundant_read_strobe_complement_o <= ~clk_rise;
      end
      dq_oe_o <= rd_on ? width_mask : 16'h0000;
      lower_byte_strobe_oe_o <= rd_on;
      lower_byte_strobe_n_oe_o <= rd_on & diff_on;
      upper_byte_strobe_oe_o <= rd_on & (org_i == `DDP_WIDTH_X16);
      upper_byte_strobe_n_oe_o <= rd_on & diff_on & (org_i == `DDP_WIDTH_X16);
      redundant_read_strobe_oe_o <= rd_on & redundant_read_strobe_complement_on;
      redundant_read_strobe_complement_oe_o <= rd_on & redundant_read_strobe_complement_on & diff_on;
    end
  end
endmodule

//--- hw/ddp_top.v
/*
  Top of the DDR2 pin block: pin logic feeding the write-beat FIFO.
  Assumes the sink drains the FIFO with valid/ready.
*/
`timescale 1ns/100ps
`include "ddp_regs.vh"
module ddp_top (
  input wire clock_i,
  input wire rst_n_i,
  input wire [1:0] org_i,
  input wire link_clk_i,
  input wire chip_select_n_i,
  input wire row_strobe_n_i,
  input wire col_strobe_n_i,
  input wire write_enable_n_i,
  input wire [2:0] bank_i,
  input wire [3:0] mode_op_i,
  input wire termination_control_i,
  input wire [15:0] dq_i,
  output wire [15:0] dq_o,
  output wire [15:0] dq_oe_o,
  input wire lower_byte_mask_i,
  input wire upper_byte_mask_i,
  input wire lower_byte_strobe_i,
  output wire [15:0] termination_on_o,
  output wire [3:0] ext_mode_o,
  output wire lower_byte_strobe_o,
  output wire lower_byte_strobe_oe_o,
  output wire redundant_read_strobe_o,
  output wire redundant_read_strobe_oe_o,
  input wire [15:0] rd_data_i,
  input wire rd_valid_i,
  output wire rd_ready_o,
  output wire sink_valid_o,
  input wire sink_ready_i,
  output wire [17:0] sink_data_o
);
  wire wv;
  wire wr;
  wire [15:0] wd;
  wire [1:0] wk;
  ddp_pins u_pins (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .org_i(org_i), .link_clk_i(link_clk_i),
    .chip_select_n_i(chip_select_n_i), .row_strobe_n_i(row_strobe_n_i),
    .col_strobe_n_i(col_strobe_n_i), .write_enable_n_i(write_enable_n_i),
    .bank_i(bank_i), .mode_op_i(mode_op_i),
    .termination_control_i(termination_control_i), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .lower_byte_mask_i(lower_byte_mask_i),
    .upper_byte_mask_i(upper_byte_mask_i), .lower_byte_strobe_i(lower_byte_strobe_i),
    .lower_byte_strobe_o(lower_byte_strobe_o),
    .lower_byte_strobe_oe_o(lower_byte_strobe_oe_o),
    .lower_byte_strobe_n_o(), .lower_byte_strobe_n_oe_o(),
    .upper_byte_strobe_o(), .upper_byte_strobe_oe_o(),
    .upper_byte_strobe_n_o(), .upper_byte_strobe_n_oe_o(),
    .redundant_read_strobe_o(redundant_read_strobe_o),
    .redundant_read_strobe_oe_o(redundant_read_strobe_oe_o),
    .redundant_read_strobe_complement_o(),
    .redundant_read_strobe_complement_oe_o(),
    .termination_on_o(termination_on_o), .last_cmd_o(), .ext_mode_o(ext_mode_o),
    .wr_valid_o(wv), .wr_ready_i(wr), .wr_data_o(wd), .wr_keep_o(wk),
    .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready_o),
    .write_stall_o()
  );
  ddp_fifo #(.WIDTH(`DDP_BEAT_W), .DEPTH(`DDP_FIFO_DEPTH), .AW(`DDP_FIFO_AW)) u_fifo (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .in_valid_i(wv), .in_ready_o(wr),
    .in_data_i({wk, wd}), .out_valid_o(sink_valid_o), .out_ready_i(sink_ready_i),
    .out_data_o(sink_data_o)
  );
endmodule

//--- bench/ddp_top_monitor.sv
/*
  Port checker for ddp_top, attached by bind.
  Assumes one clock domain with synchronous active-low reset.
*/
`timescale 1ns/100ps
module ddp_top_monitor (
  input wire clock_i,
  input wire rst_n_i,
  input wire [1:0] org_i,
  input wire chip_select_n_i,
  input wire [15:0] dq_oe_o,
  input wire [15:0] termination_on_o,
  input wire [3:0] ext_mode_o,
  input wire lower_byte_strobe_oe_o,
  input wire redundant_read_strobe_oe_o,
  input wire rd_valid_i,
  input wire rd_ready_o,
  input wire sink_valid_o,
  input wire sink_ready_i,
  input wire [17:0] sink_data_o
);
  wire [15:0] wmask = org_i == 2'h2 ? 16'hFFFF : (org_i == 2'h1 ? 16'h00FF : 16'h000F);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_desel;
    chip_select_n_i [*6];
  endsequence
  sequence s_term_off;
    ext_mode_o[0] [*2];
  endsequence
  a_term_mask: assert property ((termination_on_o & ~wmask) == 16'h0000)
    else $error("termination outside width");
  a_dq_width: assert property ((dq_oe_o & ~wmask) == 16'h0000)
    else $error("data drive outside width");
  a_redundant_read_strobe_complement_x8: assert property (redundant_read_strobe_oe_o |-> org_i == 2'h1 && ext_mode_o[2])
    else $error("redundant strobe when not enabled");
  a_redundant_read_strobe_complement_read: assert property (redundant_read_strobe_oe_o |-> lower_byte_strobe_oe_o)
    else $error("redundant strobe outside read");
  a_term_ignored: assert property (s_term_off |-> termination_on_o == 16'h0000)
    else $error("termination moved while disabled");
  a_cs_gate: assert property (s_desel |-> $stable(ext_mode_o))
    else $error("mode changed while deselected");
  a_ready_pulse: assert property (rd_ready_o |=> !rd_ready_o)
    else $error("read ready longer than one cycle");
  a_ready_valid: assert property (rd_ready_o |-> $past(rd_valid_i))
    else $error("read beat taken without valid");
  a_sink_hold: assert property (sink_valid_o && !sink_ready_i |=> sink_valid_o && $stable(sink_data_o))
    else $error("sink beat dropped while stalled");
  a_sink_keep: assert property (sink_valid_o |-> sink_data_o[17:16] != 2'h0)
    else $error("fully masked beat stored");
endmodule
bind ddp_top ddp_top_monitor i_mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .org_i(org_i),
  .chip_select_n_i(chip_select_n_i), .dq_oe_o(dq_oe_o), .termination_on_o(termination_on_o),
  .ext_mode_o(ext_mode_o), .lower_byte_strobe_oe_o(lower_byte_strobe_oe_o),
  .redundant_read_strobe_oe_o(redundant_read_strobe_oe_o), .rd_valid_i(rd_valid_i),
  .rd_ready_o(rd_ready_o), .sink_valid_o(sink_valid_o), .sink_ready_i(sink_ready_i),
  .sink_data_o(sink_data_o));

//--- bench/ddp_ctl_model.sv
/*
  Memory controller model: link clock, command pins, write beats.
  Assumes clock_i is the bench clock; link clock runs only in cycles.
*/
`timescale 1ns/100ps
module ddp_ctl_model (
  input wire clock_i,
  output reg link_clk_o,
  output reg cs_n_o,
  output reg [2:0] cmd_o,
  output reg [2:0] bank_o,
  output reg [3:0] op_o,
  output reg odt_o,
  output reg [15:0] dq_o,
  output reg lmask_o,
  output reg umask_o,
  output reg strobe_o
);
  initial begin
    {link_clk_o, cs_n_o, cmd_o, bank_o, op_o, odt_o} = 13'h0F80;
    {dq_o, lmask_o, umask_o, strobe_o} = 19'h0;
  end
  // One link clock period carrying a command
  task cyc(input c, input [2:0] k, input [2:0] b, input [3:0] op, input t);
    begin
      @(negedge clock_i);
      cs_n_o = c;
      cmd_o = k;
      bank_o = b;
      op_o = op;
      odt_o = t;
      #62.5 link_clk_o = 1'b1;
      #62.5 link_clk_o = 1'b0;
      cs_n_o = 1'b1;
    end
  endtask
  // One write beat, strobe edge in the middle of the data
  task beat(input [15:0] d, input lm, input um);
    begin
      @(negedge clock_i);
      {dq_o, lmask_o, umask_o} = {d, lm, um};
      repeat (4) @(negedge clock_i);
      strobe_o = ~strobe_o;
      repeat (4) @(negedge clock_i);
      dq_o = ~d;
    end
  endtask
endmodule

//--- bench/ddr2_cmd_data_pin_behaviour_tb.sv
/*
  Self-checking bench for ddp_top with a queue model of stored beats.
  Assumes the controller model and the bound port checker.
*/
`timescale 1ns/100ps
module ddr2_cmd_data_pin_behaviour_tb;
  reg clock_i, rst_n_i, sink_ready_i, rd_valid_i;
  reg [1:0] org_i;
  reg [15:0] rd_data_i, d, wm, pm;
  reg [31:0] r;
  wire link_clk, cs_n, termination_control, lmask, umask, strobe, lbs, lbs_oe, rrs, rrs_oe, rd_ready, sink_valid;
  wire [2:0] cmd, bank;
  wire [3:0] op, ext_mode;
  wire [15:0] dq, dq_o, dq_oe_o, term;
  wire [17:0] sink_data;
  integer fail_count, samples_checked, seed, n, k, rdy_cnt;
  reg [17:0] exp_q[$];
  ddp_ctl_model i_ctl (.clock_i(clock_i), .link_clk_o(link_clk), .cs_n_o(cs_n), .cmd_o(cmd),
    .bank_o(bank), .op_o(op), .odt_o(termination_control), .dq_o(dq), .lmask_o(lmask), .umask_o(umask),
    .strobe_o(strobe));
  ddp_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .org_i(org_i), .link_clk_i(link_clk),
    .chip_select_n_i(cs_n), .row_strobe_n_i(cmd[2]), .col_strobe_n_i(cmd[1]),
    .write_enable_n_i(cmd[0]), .bank_i(bank), .mode_op_i(op), .termination_control_i(termination_control),
    .dq_i(dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .lower_byte_mask_i(lmask),
    .upper_byte_mask_i(umask), .lower_byte_strobe_i(strobe), .termination_on_o(term),
    .ext_mode_o(ext_mode), .lower_byte_strobe_o(lbs), .lower_byte_strobe_oe_o(lbs_oe),
    .redundant_read_strobe_o(rrs), .redundant_read_strobe_oe_o(rrs_oe), .rd_data_i(rd_data_i),
    .rd_valid_i(rd_valid_i), .rd_ready_o(rd_ready), .sink_valid_o(sink_valid),
    .sink_ready_i(sink_ready_i), .sink_data_o(sink_data));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task chk(input [17:0] got, input [17:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(negedge clock_i) begin
    r = $random(seed);
    sink_ready_i <= r[0];
  end
  always @(posedge clock_i) begin
    if (rd_ready) rdy_cnt = rdy_cnt + 1;
    if (rst_n_i && sink_valid && sink_ready_i) begin
      if (exp_q.size() == 0) chk({17'h0, sink_valid}, 18'h0);
      else begin
        pm = {{8{exp_q[0][17]}}, {8{exp_q[0][16]}}};
        chk(sink_data & {2'h3, pm}, exp_q.pop_front());
      end
    end
  end
  initial begin
    #100000;
    fail_count = fail_count + 1;
    report_and_stop;
  end
  initial begin
    {seed, fail_count, samples_checked, rdy_cnt} = {32'd33345, 96'd0};
    {rst_n_i, org_i, rd_valid_i, rd_data_i, sink_ready_i} = 21'h1;
    for (k = 0; k < 3; k = k + 1) begin
      @(negedge clock_i);
      rst_n_i = 1'b0;
      org_i = k;
      repeat (2) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clock_i);
      wm = k == 2 ? 16'hFFFF : (k == 1 ? 16'h00FF : 16'h000F);
      i_ctl.cyc(1'b0, 3'h0, 3'h1, 4'h4, 1'b0);
      i_ctl.cyc(1'b0, 3'h7, 3'h0, 4'h0, 1'b1);
      chk(ext_mode, 4'h4);
      chk(term, wm);
      @(negedge clock_i);
      rdy_cnt = 0;
      d = $random(seed);
      {rd_data_i, rd_valid_i} = {d, 1'b1};
      fork
        begin
          i_ctl.cyc(1'b0, 3'h5, 3'h0, 4'h0, 1'b0);
          repeat (2) i_ctl.cyc(1'b0, 3'h7, 3'h0, 4'h0, 1'b0);
        end
        for (n = 0; n < 4; n = n + 1) begin
          @(negedge clock_i);
          while (!rd_ready) @(negedge clock_i);
          chk(dq_oe_o, wm);
          chk(dq_o & wm, d & wm);
          chk({lbs_oe, rrs_oe, lbs, rrs & rrs_oe}, {1'b1, k == 1, n[0], n[0] & (k == 1)});
          chk(rdy_cnt, n);
          d = $random(seed);
          rd_data_i = d;
        end
      join
      chk(rdy_cnt, 4);
      rd_valid_i = 1'b0;
    end
    i_ctl.cyc(1'b1, 3'h0, 3'h1, 4'h1, 1'b0);
    chk(ext_mode, 4'h4);
    chk(term, 16'h0000);
    i_ctl.cyc(1'b0, 3'h0, 3'h1, 4'h1, 1'b0);
    i_ctl.cyc(1'b0, 3'h7, 3'h0, 4'h0, 1'b1);
    chk({ext_mode, term}, {4'h1, 16'h0000});
    i_ctl.cyc(1'b0, 3'h0, 3'h1, 4'h0, 1'b0);
    for (k = 0; k < 3; k = k + 1) begin
      i_ctl.cyc(1'b0, 3'h4, 3'h0, 4'h0, 1'b0);
      for (n = 0; n < 4; n = n + 1) begin
        r = $random(seed);
        pm = {{8{~r[17]}}, {8{~r[16]}}};
        if (r[17:16] != 2'h3) exp_q.push_back({~r[17:16], r[15:0] & pm});
        i_ctl.beat(r[15:0], r[16], r[17]);
      end
    end
    for (n = 0; n < 200 && exp_q.size() != 0; n = n + 1) @(negedge clock_i);
    chk(exp_q.size(), 18'h0);
    report_and_stop;
  end
endmodule
